// ### sram_ctl_consts.svh
// timing counts for the static memory controller
`ifndef SRAM_CTL_CONSTS_SVH
`define SRAM_CTL_CONSTS_SVH
`define CLK_PERIOD_NS    8
`define TRC_NS           10
`define TWC_NS           10
`define TSD_NS           7
`define TDOE_NS          6
`define THZ_NS           6
// least times round up, none below one cycle
`define CYC_UP(t)        ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                          (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define ACCESS_CYC       (`CYC_UP(`TRC_NS) + 1)
`define WRITE_CYC        `CYC_UP(`TWC_NS)
`define TURN_CYC         `CYC_UP(`THZ_NS)
`endif

// ### sram_ctl_pkg.sv
// types for the static memory controller
package sram_ctl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_READ  = 3'b001,
        ST_WRITE = 3'b010,
        ST_END   = 3'b011,
        ST_TURN  = 3'b100
    } state_type;
endpackage : sram_ctl_pkg

// ### sram_pin_sync.sv
// two-stage synchroniser for the data pins coming back from the memory
`timescale 1ns/10ps
module sram_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             MCLK,
    input  wire logic             SYS_RST,
    input  wire logic             CE,
    input  wire logic [WIDTH-1:0] D,
    output logic      [WIDTH-1:0] Q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_type;
    sync_type s_reg;
    sync_type s_next;
    // first stage feeds only the second
    always_comb
    begin
        s_next = s_reg;
        if (CE)
        begin
            s_next.meta = D;
            s_next.sync = s_reg.meta;
        end
    end
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end
    assign Q = s_reg.sync;
endmodule : sram_pin_sync

// ### sram_ctl.sv
// host controller that runs read and write cycles on an asynchronous static memory
//
// Summary of operation
// [RULE1] write strobe stays high throughout every read access.
// [RULE2] in a read, chip select and output gate stay low and the data follows the address.
// [RULE3] the address is valid no later than chip select going low.
// [RULE4] the memory stores only while chip select and write strobe are low together.
// [RULE5] a write starts with all controls valid and ends when either strobe rises.
// [RULE6] write data is stable around the strobe edge that ends the write.
// [RULE7] with output gate high during a write the memory floats its data lines.
// [RULE8] the memory drives data only with chip select and output gate low and write strobe high.
`timescale 1ns/10ps
`include "sram_ctl_consts.svh"
module sram_ctl #(
    parameter int AW = 13,
    parameter int DW = 8
) (
    input  wire logic                    MCLK,
    input  wire logic                    SYS_RST,
    input  wire logic                    CLK_EN,
    input  wire logic                    REQ_VALID,
    output logic                         REQ_READY,
    input  wire logic                    REQ_WRITE,
    input  wire logic [AW-1:0]           REQ_ADDR,
    input  wire logic [DW-1:0]           REQ_WDATA,
    output logic                         RD_VALID,
    output logic      [DW-1:0]           RD_DATA,
    output logic                         MEM_CS_N,
    output logic                         MEM_WE_N,
    output logic                         MEM_OE_N,
    output logic      [AW-1:0]           MEM_ADDR,
    input  wire logic [DW-1:0]           MEM_DQ_I,
    output logic      [DW-1:0]           MEM_DQ_O,
    output logic                         MEM_DQ_OE,
    output sram_ctl_pkg::state_type      STATE
);
    import sram_ctl_pkg::*;

    localparam int ACC  = `ACCESS_CYC + 2; // includes two synchroniser stages
    localparam int WRC  = `WRITE_CYC;
    localparam int TRN  = `TURN_CYC;
    localparam int CW   = 4;

    typedef struct packed {
        state_type        st;
        logic [CW-1:0]    cnt;
        logic             cs_n;
        logic             we_n;
        logic             oe_n;
        logic [AW-1:0]    addr;
        logic [DW-1:0]    wdata;
        logic             dq_oe;
        logic             rvalid;
        logic [DW-1:0]    rdata;
    } ctl_type;

    ctl_type c_reg;
    ctl_type c_next;
    logic [DW-1:0] dq_sync;

    // data pins come from outside the clock domain
    sram_pin_sync #(
        .WIDTH(DW)
    ) u_sync (
        .MCLK    (MCLK),
        .SYS_RST (SYS_RST),
        .CE      (CLK_EN),
        .D       (MEM_DQ_I),
        .Q       (dq_sync)
    );

    // cycle sequencer
    always_comb
    begin
        c_next = c_reg;
        c_next.rvalid = 1'b0;
        if (CLK_EN)
        begin
            unique case (c_reg.st)
                ST_IDLE:
                begin
                    if (REQ_VALID)
                    begin
                        c_next.addr = REQ_ADDR;              // address set with select edge RULE3
                        c_next.cs_n = 1'b0;
                        c_next.cnt  = '0;
                        if (REQ_WRITE)
                        begin
                            c_next.st    = ST_WRITE;
                            c_next.wdata = REQ_WDATA;         // data steady for whole strobe RULE6
                            c_next.dq_oe = 1'b1;
                            c_next.oe_n  = 1'b1;              // memory floats its outputs RULE7
                            c_next.we_n  = 1'b0;              // strobe joins a valid select RULE5
                        end
                        else
                        begin
                            c_next.st   = ST_READ;
                            c_next.we_n = 1'b1;               // RULE1
                            c_next.oe_n = 1'b0;               // RULE2
                        end
                    end
                end
                ST_READ:
                begin
                    if (c_reg.cnt == CW'(ACC - 1))
                    begin
                        c_next.rdata  = dq_sync;              // read data valid while driven RULE8
                        c_next.rvalid = 1'b1;
                        c_next.cs_n   = 1'b1;
                        c_next.oe_n   = 1'b1;
                        c_next.cnt    = '0;
                        c_next.st     = ST_TURN;
                    end
                    else
                        c_next.cnt = c_reg.cnt + CW'(1);
                end
                ST_WRITE:
                begin
                    if (c_reg.cnt == CW'(WRC - 1))
                    begin
                        c_next.we_n = 1'b1;                   // rising strobe ends the store RULE4
                        c_next.st   = ST_END;
                    end
                    else
                        c_next.cnt = c_reg.cnt + CW'(1);
                end
                ST_END:
                begin
                    // data held one cycle after the ending edge
                    c_next.cs_n  = 1'b1;
                    c_next.dq_oe = 1'b0;
                    c_next.cnt   = '0;
                    c_next.st    = ST_TURN;
                end
                ST_TURN:
                begin
                    if (c_reg.cnt == CW'(TRN - 1))
                        c_next.st = ST_IDLE;
                    else
                        c_next.cnt = c_reg.cnt + CW'(1);
                end
                default:
                    c_next.st = ST_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            c_reg       <= '0;
            c_reg.st    <= ST_IDLE;
            c_reg.cs_n  <= 1'b1;
            c_reg.we_n  <= 1'b1;
            c_reg.oe_n  <= 1'b1;
        end
        else
            c_reg <= c_next;
    end

    assign REQ_READY = CLK_EN && (c_reg.st == ST_IDLE);
    assign RD_VALID  = c_reg.rvalid;
    assign RD_DATA   = c_reg.rdata;
    assign MEM_CS_N  = c_reg.cs_n;
    assign MEM_WE_N  = c_reg.we_n;
    assign MEM_OE_N  = c_reg.oe_n;
    assign MEM_ADDR  = c_reg.addr;
    assign MEM_DQ_O  = c_reg.wdata;
    assign MEM_DQ_OE = c_reg.dq_oe;
    assign STATE     = c_reg.st;

    // write strobe never low while output gate low
    read_we_high_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !MEM_OE_N |-> MEM_WE_N) else $error("write strobe low during read"); // RULE1
    // read holds select and gate low the first three cycles of the access
    read_strobes_low_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (STATE == ST_READ && $past(STATE) == ST_IDLE) |-> (!MEM_CS_N && !MEM_OE_N) [*3])
        else $error("read strobes not held"); // RULE2
    // address stable while selected
    addr_stable_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (!MEM_CS_N && !$past(MEM_CS_N)) |-> $stable(MEM_ADDR)) else $error("address moved while selected"); // RULE3
    // write strobe only inside select
    we_in_cs_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !MEM_WE_N |-> !MEM_CS_N) else $error("write strobe outside select"); // RULE4
    // write strobe pulse lasts the write count
    we_pulse_len_a: assert property (@(posedge MCLK) disable iff (SYS_RST || !CLK_EN)
        $fell(MEM_WE_N) |-> !MEM_WE_N [*2] ##1 MEM_WE_N) else $error("write pulse length wrong"); // RULE5
    // data driven and stable across write end
    data_hold_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        $rose(MEM_WE_N) |-> MEM_DQ_OE && $stable(MEM_DQ_O)) else $error("write data not held"); // RULE6
    // gate high whenever host drives data
    no_contention_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        MEM_DQ_OE |-> MEM_OE_N) else $error("bus contention"); // RULE7
    // read result follows the access
    read_result_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
        RD_VALID |-> (MEM_CS_N && STATE == ST_TURN)) else $error("read result out of place"); // RULE8
endmodule : sram_ctl

// ### sram_model.sv
// behavioural static memory answering the host controller's strobes
`timescale 1ns/10ps
module sram_model #(
    parameter int AW = 13,
    parameter int DW = 8
) (
    input  wire logic          cs_n,
    input  wire logic          we_n,
    input  wire logic          oe_n,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] din,
    output logic      [DW-1:0] dout,
    output logic               drive
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] last = '0;
    // store only while select and write strobe overlap, either rising ends it
    always @*
    begin
        if (!cs_n && !we_n)
            mem[addr] = din;
    end
    // drive only when read is selected, float on select high or gate high
    assign drive = !cs_n && !oe_n && we_n;
    always @*
    begin
        if (drive)
            last = mem[addr];
    end
    // a floating line shows the inverse of its last value, never a kind zero
    assign dout = drive ? mem[addr] : ~last;
endmodule : sram_model

// ### async_sram_read_write_cycles_tb_top.sv
// self-checking bench for the static memory host controller
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module async_sram_read_write_cycles_tb_top;
    import sram_ctl_pkg::*;
    logic        MCLK = 0, SYS_RST = 1, CLK_EN = 1, REQ_VALID = 0, REQ_WRITE = 0;
    logic [12:0] REQ_ADDR = '0;
    logic [7:0]  REQ_WDATA = '0;
    logic        REQ_READY, RD_VALID, MEM_CS_N, MEM_WE_N, MEM_OE_N, MEM_DQ_OE, drive;
    logic [7:0]  RD_DATA, MEM_DQ_O, dout, dq;
    logic [12:0] MEM_ADDR;
    state_type   STATE;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    logic [7:0]  ref_mem [0:8191];
    bit          written [0:8191];
    int          wq[$];
    // clock and resolved data wire
    always #4 MCLK = ~MCLK;
    assign dq = MEM_DQ_OE ? MEM_DQ_O : dout;
    sram_ctl i_sram_ctl (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .REQ_VALID(REQ_VALID),
        .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
        .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .MEM_CS_N(MEM_CS_N), .MEM_WE_N(MEM_WE_N),
        .MEM_OE_N(MEM_OE_N), .MEM_ADDR(MEM_ADDR), .MEM_DQ_I(dq), .MEM_DQ_O(MEM_DQ_O),
        .MEM_DQ_OE(MEM_DQ_OE), .STATE(STATE));
    sram_model i_sram_model (.cs_n(MEM_CS_N), .we_n(MEM_WE_N), .oe_n(MEM_OE_N), .addr(MEM_ADDR),
        .din(MEM_DQ_O), .dout(dout), .drive(drive));
    // expected read value from the bench's own copy
    function automatic logic [7:0] exp_read(input logic [12:0] a);
        return ref_mem[a];
    endfunction : exp_read
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // one request, taken when ready, then pin and read data checks
    task automatic do_op(input bit w, input logic [12:0] a, input logic [7:0] d);
        int k;
        @(posedge MCLK);
        REQ_VALID <= 1'b1;
        REQ_WRITE <= w;
        REQ_ADDR  <= a;
        REQ_WDATA <= d;
        k = 0;
        do begin @(negedge MCLK); k++; end while (REQ_READY !== 1'b1 && k < 20);
        `CHK(REQ_READY, 1'b1)
        @(posedge MCLK);
        REQ_VALID <= 1'b0;
        REQ_ADDR  <= 13'($urandom);
        k = 0;
        do begin @(negedge MCLK); k++; end while (MEM_CS_N !== 1'b0 && k < 10);
        `CHK(MEM_CS_N, 1'b0)
        `CHK(MEM_ADDR, a)
        if (w)
        begin
            ref_mem[a] = d;
            if (!written[a])
                wq.push_back(a);
            written[a] = 1;
        end
        else
        begin
            k = 0;
            while (RD_VALID !== 1'b1 && k < 10) begin @(negedge MCLK); k++; end
            `CHK(RD_VALID, 1'b1)
            `CHK(RD_DATA, exp_read(a))
        end
    endtask : do_op
    // pin watch: no write strobe in a read, data driven while writing
    always @(negedge MCLK)
    begin
        if (!SYS_RST && STATE === ST_READ)
            `CHK(MEM_WE_N, 1'b1)
        if (!SYS_RST && MEM_WE_N === 1'b0)
            `CHK(MEM_DQ_OE & ~MEM_CS_N, 1'b1)
    end
    // hang guard
    always @(posedge MCLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            bad_count++;
            end_sim();
        end
    end
    // main sequence
    initial
    begin
        bit w;
        logic [12:0] a;
        void'($urandom(18647));
        repeat (6) @(posedge MCLK);
        SYS_RST <= 1'b0;
        @(negedge MCLK);
        `CHK(STATE, ST_IDLE)
        `CHK(MEM_CS_N, 1'b1)
        do_op(1, 13'h0000, 8'ha5);
        do_op(1, 13'h1fff, 8'h5a);
        do_op(0, 13'h0000, 8'h00);
        do_op(0, 13'h1fff, 8'h00);
        $display("test corners done");
        @(posedge MCLK);
        CLK_EN    <= 1'b0;
        REQ_VALID <= 1'b1;
        REQ_WRITE <= 1'b1;
        REQ_WDATA <= 8'hff;
        repeat (3) @(negedge MCLK);
        `CHK(REQ_READY, 1'b0)
        `CHK(MEM_CS_N, 1'b1)
        @(posedge MCLK);
        CLK_EN    <= 1'b1;
        REQ_VALID <= 1'b0;
        do_op(0, 13'h0000, 8'h00);
        $display("test freeze done");
        repeat (300)
        begin
            w = (wq.size() == 0) || $urandom_range(1);
            a = w ? 13'($urandom) : 13'(wq[$urandom_range(wq.size() - 1)]);
            do_op(w, a, 8'($urandom));
        end
        $display("test random done");
        end_sim();
    end
endmodule : async_sram_read_write_cycles_tb_top
